// File: hw/mtcfg_regs.vh
`ifndef MTCFG_REGS_VH
`define MTCFG_REGS_VH
// register indexes; byte address is four times the index
`define MTCFG_IDX_WAIT        8'h63
`define MTCFG_IDX_VERSION     8'h64
`define MTCFG_IDX_ROMCFG      8'h65
`define MTCFG_IDX_EXT         8'h70
`define MTCFG_IDX_STATUS      8'h71
// wait state control fields
`define MTCFG_WS_SHUTDOWN_WAIT_SEL        0
`define MTCFG_WS_WIDEIO       2
`define MTCFG_WS_INTIO        3
`define MTCFG_WS_FCYC_LO      4
`define MTCFG_WS_FCYC_HI      5
`define MTCFG_WS_BANK_MISS_WAIT_SEL       6
`define MTCFG_WS_SMSIZE       7
// refresh/page select fields
`define MTCFG_RP_EPM          4
// rom/shadow fields
`define MTCFG_RC_SEGF_N       0
`define MTCFG_RC_SEGE         1
`define MTCFG_RC_SEGD         2
`define MTCFG_RC_SEGC         3
`define MTCFG_RC_SHADOW       4
`define MTCFG_RC_PAGE_FIRST_WAIT_SEL         5
`define MTCFG_RC_WINA         6
`define MTCFG_RC_WALLOW       7
// extended register: miss-timeout and neighbour-register inputs
`define MTCFG_EX_MISS_TIMEOUT_SEL       0
`define MTCFG_RST_BYTE        8'h00
// status register fields
`define MTCFG_ST_MISS_TIMEOUT_SEL       0
// wait counts
`define MTCFG_FC_1            3'd1
`define MTCFG_FC_2            3'd2
`define MTCFG_FC_3            3'd3
`define MTCFG_BM_3            3'd3
`define MTCFG_BM_4            3'd4
`define MTCFG_BM_5            3'd5
`define MTCFG_INTIO_SLOW      3'd4
`define MTCFG_INTIO_FAST      3'd2
`define MTCFG_WIDEIO_SLOW     3'd4
`define MTCFG_WIDEIO_FAST     3'd3
`define MTCFG_SHUT_SHORT      6'd16
`define MTCFG_SHUT_LONG       6'd32
// refresh rates, cycles per second
`define MTCFG_REF_0           16'd8192
`define MTCFG_REF_1           16'd10922
`define MTCFG_REF_2           16'd16384
`define MTCFG_REF_3           16'd32768
// window base address and sizes
`define MTCFG_SMW_BASE        20'h60000
`define MTCFG_SMW_16K         20'h04000
`define MTCFG_SMW_64K         20'h10000
`define MTCFG_BANKCFG_EPM     3'b010
// resp codes
`define MTCFG_RESP_OKAY       2'b00
`define MTCFG_RESP_SLVERR     2'b10
`endif

// File: hw/mtcfg_keep.v
`include "mtcfg_regs.vh"
// refresh field store; deliberately not cleared on micro power-off exit
module mtcfg_keep (
  input  wire       mclk,
  input  wire       sys_rst,
  input  wire       wr_en,
  input  wire [1:0] wr_data,
  output reg  [1:0] q_reg
);
  always @(posedge mclk) begin
    if (sys_rst) begin
      q_reg <= 2'b00;
    end else if (wr_en) begin
      q_reg <= wr_data;
    end
  end
endmodule

// File: hw/mtcfg_top.v
// Overview of operation
// - window size bit: 0 maps 16K, 1 maps 64K at 60000h during interrupt
// - first-cycle wait: page-first bit picks lo bit (1/2) or hi bit (2/3)
// - bank-miss wait 3 unless miss-timeout set, then 4 or 5 by bit
// - internal core I/O takes 4 waits at 0, 2 waits at 1
// - 16-bit I/O takes 4 waits at 0, 3 waits at 1
// - shutdown cycle lasts 16 cycles at 0, 32 at 1
// - version read bit 7 shows interrupt active
// - version read gives major stepping bits 2-0, minor bits 6-3
// - version write loads refresh and enhanced page, not status
// - refresh code selects 8192, 10922, 16384 or 32768 per second
// - refresh code used only when power-manager low bits are both zero
// - refresh code survives leaving micro power-off
// - enhanced page needs write bit, bank cfg 010, ext bit7 0, mem bit0 1
// - segment C, D, E bits enable rom select for their 64K range
// - segment F bit active low, reads back inverted
// - bit 4 enables shadow, bit 7 allows shadow writes
// - global window bit clear disables the page windows but not the interrupt window, else per-page bit 7
// - miss-timeout bit lives in a neighbour register
//
// Added by the designer: register access over AXI4-Lite.
`include "mtcfg_regs.vh"
module mtcfg_top #(
  parameter [3:0] MINOR_STEP = 4'h5, // arbitrary value
  parameter [2:0] MAJOR_STEP = 3'h6  // arbitrary value
) (
  input  wire        mclk,
  input  wire        sys_rst,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        sys_mgmt_interrupt,
  input  wire [1:0]  power_manager,
  input  wire [2:0]  mem_bank_cfg,
  input  wire        mem_cfg_bit0,
  input  wire        ext_cfg_bit7,
  input  wire [23:0] mem_addr,
  input  wire        mem_wr,
  input  wire        window_page_en,
  output reg         bios_rom_select_n,
  output reg         shadow_hit,
  output reg         shadow_write_ok,
  output reg         sys_mgmt_window_hit,
  output reg         window_active,
  output reg  [2:0]  first_cycle_waits,
  output reg  [2:0]  bank_miss_waits,
  output reg  [2:0]  internal_io_waits,
  output reg  [2:0]  wide_io_waits,
  output reg  [5:0]  shutdown_cycles,
  output reg         refresh_from_regs,
  output reg  [15:0] refresh_rate,
  output reg         enhanced_page_enable
);
  // pins from outside the clock domain pass two flip-flops
  // limitation: wide levels are caught bit by bit; hold them two cycles
  reg        smi_s1_reg;
  reg        smi_s2_reg;
  reg [1:0]  pm_s1_reg;
  reg [1:0]  pm_s2_reg;
  reg        wpe_s1_reg;
  reg        wpe_s2_reg;
  reg [23:0] addr_s1_reg;
  reg [23:0] addr_s2_reg;
  reg        wr_s1_reg;
  reg        wr_s2_reg;
  reg [4:0]  cfg_s1_reg;
  reg [4:0]  cfg_s2_reg;
  always @(posedge mclk) begin
    if (sys_rst) begin
      smi_s1_reg  <= 1'b0;
      smi_s2_reg  <= 1'b0;
      pm_s1_reg   <= 2'b00;
      pm_s2_reg   <= 2'b00;
      wpe_s1_reg  <= 1'b0;
      wpe_s2_reg  <= 1'b0;
      addr_s1_reg <= 24'h000000;
      addr_s2_reg <= 24'h000000;
      wr_s1_reg   <= 1'b0;
      wr_s2_reg   <= 1'b0;
      cfg_s1_reg  <= 5'h00;
      cfg_s2_reg  <= 5'h00;
    end else begin
      smi_s1_reg  <= sys_mgmt_interrupt;
      smi_s2_reg  <= smi_s1_reg;
      pm_s1_reg   <= power_manager;
      pm_s2_reg   <= pm_s1_reg;
      wpe_s1_reg  <= window_page_en;
      wpe_s2_reg  <= wpe_s1_reg;
      addr_s1_reg <= mem_addr;
      addr_s2_reg <= addr_s1_reg;
      wr_s1_reg   <= mem_wr;
      wr_s2_reg   <= wr_s1_reg;
      cfg_s1_reg  <= {ext_cfg_bit7, mem_cfg_bit0, mem_bank_cfg};
      cfg_s2_reg  <= cfg_s1_reg;
    end
  end

  // configuration storage
  reg  [7:0] wait_state_control_reg;
  reg  [4:0] page_sel_reg;       // upper bits of the write-only version set
  reg  [7:0] rom_and_shadow_config_reg;
  reg        miss_timeout_sel_reg;
  wire [1:0] refresh_interval;
  wire [7:0] stepping_and_smi_status;

  // write channel holding
  reg [9:0]  aw_idx_reg;
  reg        aw_held_reg;
  reg [31:0] w_data_reg;
  reg [3:0]  w_strb_reg;
  reg        w_held_reg;
  wire       do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
  wire       lane0    = w_strb_reg[0];

  // upper two index bits must be zero to hit
  function is_idx;
    input [9:0] idx;
    input [7:0] want;
    begin
      is_idx = (idx == {2'b00, want});
    end
  endfunction

  wire wr_wait = do_write && lane0 && is_idx(aw_idx_reg, `MTCFG_IDX_WAIT);
  wire wr_ver  = do_write && lane0 && is_idx(aw_idx_reg, `MTCFG_IDX_VERSION);
  wire wr_rom  = do_write && lane0 && is_idx(aw_idx_reg, `MTCFG_IDX_ROMCFG);
  wire wr_ext  = do_write && lane0 && is_idx(aw_idx_reg, `MTCFG_IDX_EXT);
  // unmapped indexes still complete, with an error response
  wire wr_hit  = is_idx(aw_idx_reg, `MTCFG_IDX_WAIT) ||
                 is_idx(aw_idx_reg, `MTCFG_IDX_VERSION) ||
                 is_idx(aw_idx_reg, `MTCFG_IDX_ROMCFG) ||
                 is_idx(aw_idx_reg, `MTCFG_IDX_EXT);

  always @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `MTCFG_RESP_OKAY;
      aw_idx_reg    <= 10'h000;
      aw_held_reg   <= 1'b0;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
      w_held_reg    <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_idx_reg    <= s_axi_awaddr[11:2];
        aw_held_reg   <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        w_held_reg   <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      // response waits for both halves; readies stay low until it is taken
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `MTCFG_RESP_OKAY : `MTCFG_RESP_SLVERR;
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      wait_state_control_reg    <= `MTCFG_RST_BYTE;
      page_sel_reg              <= 5'h00;
      // zero leaves segment F selected so boot code stays reachable
      rom_and_shadow_config_reg <= `MTCFG_RST_BYTE;
      miss_timeout_sel_reg      <= 1'b0;
    end else begin
      if (wr_wait) begin
        wait_state_control_reg <= w_data_reg[7:0];
      end
      if (wr_ver) begin
        page_sel_reg <= w_data_reg[7:3];
      end
      if (wr_rom) begin
        // kept as written; the segment F bit is active low
        rom_and_shadow_config_reg <= w_data_reg[7:0];
      end
      if (wr_ext) begin
        miss_timeout_sel_reg <= w_data_reg[`MTCFG_EX_MISS_TIMEOUT_SEL];
      end
    end
  end

  // refresh code held in its own module, reset only by system reset
  mtcfg_keep u_refresh (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .wr_en   (wr_ver),
    .wr_data (w_data_reg[1:0]),
    .q_reg   (refresh_interval)
  );

  assign stepping_and_smi_status = {smi_s2_reg, MINOR_STEP, MAJOR_STEP};

  // read channel
  // data captured with the address, so a later write cannot tear it
  reg [7:0] rd_byte;
  reg       rd_hit;
  always @* begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    case (s_axi_araddr[11:2])
      {2'b00, `MTCFG_IDX_VERSION}: rd_byte = stepping_and_smi_status;
      {2'b00, `MTCFG_IDX_ROMCFG}: begin
        rd_byte = rom_and_shadow_config_reg;
        rd_byte[`MTCFG_RC_SEGF_N] = ~rom_and_shadow_config_reg[`MTCFG_RC_SEGF_N];
      end
      {2'b00, `MTCFG_IDX_STATUS}: rd_byte = {7'h00, miss_timeout_sel_reg};
      // write-only registers read as zero
      {2'b00, `MTCFG_IDX_WAIT}: rd_byte = 8'h00;
      {2'b00, `MTCFG_IDX_EXT}: rd_byte = 8'h00;
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `MTCFG_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h000000, rd_byte};
        s_axi_rresp   <= rd_hit ? `MTCFG_RESP_OKAY : `MTCFG_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // decoded settings
  wire [7:0] ws = wait_state_control_reg;
  wire [7:0] rc = rom_and_shadow_config_reg;
  wire [3:0] seg = addr_s2_reg[19:16];
  wire       low_meg = (addr_s2_reg[23:20] == 4'h0);
  wire [19:0] win_size = ws[`MTCFG_WS_SMSIZE] ? `MTCFG_SMW_64K : `MTCFG_SMW_16K;
  // the 64K page ends just below 70000h, the 16K page below 64000h
  wire       in_win = low_meg && (addr_s2_reg[19:0] >= `MTCFG_SMW_BASE) &&
                      (addr_s2_reg[19:0] < (`MTCFG_SMW_BASE + win_size));
  wire       smw_hit    = smi_s2_reg && in_win;
  reg        rom_en;
  always @* begin
    case (seg)
      4'hC:    rom_en = rc[`MTCFG_RC_SEGC];
      4'hD:    rom_en = rc[`MTCFG_RC_SEGD];
      4'hE:    rom_en = rc[`MTCFG_RC_SEGE];
      4'hF:    rom_en = ~rc[`MTCFG_RC_SEGF_N];
      default: rom_en = 1'b0;
    endcase
  end
  wire       shadow_seg = low_meg && (seg >= 4'hC) && rc[`MTCFG_RC_SHADOW];
  wire       rom_hit    = low_meg && rom_en;
  // writes pass only with the allow bit set
  wire       shadow_wr  = shadow_seg && wr_s2_reg && rc[`MTCFG_RC_WALLOW];
  wire       win_req    = rc[`MTCFG_RC_WINA] && wpe_s2_reg;
  wire       regs_rate  = (pm_s2_reg == 2'b00);
  // enhanced page only with the two-bank layout, ext bit 7 clear and mem bit 0 set
  wire       epm_req    = page_sel_reg[`MTCFG_RP_EPM - 3];
  wire       epm_bank   = (cfg_s2_reg[2:0] == `MTCFG_BANKCFG_EPM);
  wire       epm_ext    = !cfg_s2_reg[4] && cfg_s2_reg[3];


  always @(posedge mclk) begin
    if (sys_rst) begin
      bios_rom_select_n    <= 1'b1;
      shadow_hit           <= 1'b0;
      shadow_write_ok      <= 1'b0;
      sys_mgmt_window_hit  <= 1'b0;
      window_active        <= 1'b0;
      first_cycle_waits    <= `MTCFG_FC_1;
      bank_miss_waits      <= `MTCFG_BM_3;
      internal_io_waits    <= `MTCFG_INTIO_SLOW;
      wide_io_waits        <= `MTCFG_WIDEIO_SLOW;
      shutdown_cycles      <= `MTCFG_SHUT_SHORT;
      refresh_from_regs    <= 1'b1;
      refresh_rate         <= `MTCFG_REF_0;
      enhanced_page_enable <= 1'b0;
    end else begin
      bios_rom_select_n   <= ~rom_hit;
      shadow_hit          <= shadow_seg;
      shadow_write_ok     <= shadow_wr;
      sys_mgmt_window_hit <= smw_hit;
      window_active       <= win_req;
      if (rc[`MTCFG_RC_PAGE_FIRST_WAIT_SEL]) begin
        first_cycle_waits <= ws[`MTCFG_WS_FCYC_HI] ? `MTCFG_FC_3 : `MTCFG_FC_2;
      end else begin
        first_cycle_waits <= ws[`MTCFG_WS_FCYC_LO] ? `MTCFG_FC_2 : `MTCFG_FC_1;
      end
      if (!miss_timeout_sel_reg) begin
        bank_miss_waits <= `MTCFG_BM_3;
      end else begin
        bank_miss_waits <= ws[`MTCFG_WS_BANK_MISS_WAIT_SEL] ? `MTCFG_BM_5 : `MTCFG_BM_4;
      end
      internal_io_waits <= ws[`MTCFG_WS_INTIO] ? `MTCFG_INTIO_FAST
                                               : `MTCFG_INTIO_SLOW;
      wide_io_waits     <= ws[`MTCFG_WS_WIDEIO] ? `MTCFG_WIDEIO_FAST
                                                : `MTCFG_WIDEIO_SLOW;
      shutdown_cycles   <= ws[`MTCFG_WS_SHUTDOWN_WAIT_SEL] ? `MTCFG_SHUT_LONG
                                               : `MTCFG_SHUT_SHORT;
      // power manager owns the interval whenever either low bit is set
      refresh_from_regs <= regs_rate;
      case (refresh_interval)
        2'b00:   refresh_rate <= `MTCFG_REF_0;
        2'b01:   refresh_rate <= `MTCFG_REF_1;
        2'b10:   refresh_rate <= `MTCFG_REF_2;
        default: refresh_rate <= `MTCFG_REF_3;
      endcase
      enhanced_page_enable <= epm_req && epm_bank && epm_ext;
    end
  end
endmodule

// File: tb/mtcfg_assertions.sv
module mtcfg_assertions (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic [1:0]  power_manager,
  input wire logic        refresh_from_regs,
  input wire logic [23:0] mem_addr,
  input wire logic        bios_rom_select_n,
  input wire logic        shadow_hit,
  input wire logic        sys_mgmt_interrupt,
  input wire logic        sys_mgmt_window_hit,
  input wire logic        window_page_en,
  input wire logic        window_active,
  input wire logic [2:0]  first_cycle_waits,
  input wire logic [2:0]  bank_miss_waits,
  input wire logic [5:0]  shutdown_cycles,
  input wire logic [15:0] refresh_rate,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // five cycles covers the input sync plus output register lag
  property p_ref_src;
    $stable(power_manager) [*5] |-> refresh_from_regs == (power_manager == 2'h0);
  endproperty
  a_ref_src: assert property (p_ref_src) else $error("refresh source wrong");
  property p_rom_out;
    (mem_addr[23:18] != 6'h03) [*5] |-> bios_rom_select_n;
  endproperty
  a_rom_out: assert property (p_rom_out) else $error("rom select outside range");
  property p_shd_out;
    (mem_addr[23:18] != 6'h03) [*5] |-> !shadow_hit;
  endproperty
  a_shd_out: assert property (p_shd_out) else $error("shadow hit outside range");
  property p_smw_off;
    (!sys_mgmt_interrupt) [*5] |-> !sys_mgmt_window_hit;
  endproperty
  a_smw_off: assert property (p_smw_off) else $error("window hit without interrupt");
  property p_win_off;
    (!window_page_en) [*5] |-> !window_active;
  endproperty
  a_win_off: assert property (p_win_off) else $error("window active without page");
  property p_fc_set;
    first_cycle_waits inside {3'h1, 3'h2, 3'h3};
  endproperty
  a_fc_set: assert property (p_fc_set) else $error("first cycle wait illegal");
  property p_bm_set;
    bank_miss_waits inside {3'h3, 3'h4, 3'h5};
  endproperty
  a_bm_set: assert property (p_bm_set) else $error("bank miss wait illegal");
  property p_sd_set;
    shutdown_cycles == 6'h10 || shutdown_cycles == 6'h20;
  endproperty
  a_sd_set: assert property (p_sd_set) else $error("shutdown count illegal");
  property p_rate_set;
    refresh_from_regs |-> refresh_rate inside {16'h2000, 16'h2AAA, 16'h4000, 16'h8000};
  endproperty
  a_rate_set: assert property (p_rate_set) else $error("refresh rate illegal");
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late or wide");
endmodule
bind mtcfg_top mtcfg_assertions u_chk (.mclk, .sys_rst, .power_manager, .refresh_from_regs,
  .mem_addr, .bios_rom_select_n, .shadow_hit, .sys_mgmt_interrupt, .sys_mgmt_window_hit,
  .window_page_en, .window_active, .first_cycle_waits, .bank_miss_waits, .shutdown_cycles,
  .refresh_rate, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata);

// File: tb/memory_timing_config_regs_tb.sv
`include "mtcfg_regs.vh"
module memory_timing_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0, sys_rst = 1'b1, mem_wr = 1'b1, window_page_en = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, rd;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sys_mgmt_interrupt = 1'b0;
  logic [1:0]  power_manager = 2'h0, rs;
  logic [2:0]  mem_bank_cfg = 3'h2;
  logic        mem_cfg_bit0 = 1'b1, ext_cfg_bit7 = 1'b0;
  logic [23:0] mem_addr = 24'h0F8000;
  logic [7:0]  w;
  logic [23:0] seg [4] = '{24'h0C1234, 24'h0D0000, 24'h0EFFFF, 24'h0F8000};
  logic [15:0] rate [4] = '{16'h2000, 16'h2AAA, 16'h4000, 16'h8000};
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         bios_rom_select_n, shadow_hit, shadow_write_ok, sys_mgmt_window_hit;
  wire         window_active, refresh_from_regs, enhanced_page_enable;
  wire  [2:0]  first_cycle_waits, bank_miss_waits, internal_io_waits, wide_io_waits;
  wire  [5:0]  shutdown_cycles;
  wire  [15:0] refresh_rate;
  int          n_mismatch = 0, checks_done = 0;
  always #2 mclk = ~mclk;
  // stepping codes are arbitrary values
  mtcfg_top #(.MINOR_STEP(4'h9), .MAJOR_STEP(3'h5)) dut (.mclk, .sys_rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sys_mgmt_interrupt,
    .power_manager, .mem_bank_cfg, .mem_cfg_bit0, .ext_cfg_bit7, .mem_addr, .mem_wr,
    .window_page_en, .bios_rom_select_n, .shadow_hit, .shadow_write_ok, .sys_mgmt_window_hit,
    .window_active, .first_cycle_waits, .bank_miss_waits, .internal_io_waits, .wide_io_waits,
    .shutdown_cycles, .refresh_from_regs, .refresh_rate, .enhanced_page_enable);
  task automatic print_verdict;
    if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bit done;
    @(posedge mclk);
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge mclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task automatic rdr(input logic [7:0] idx);
    bit done;
    @(posedge mclk);
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge mclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    rdr(idx);
    chk(rd, exp);
  endtask
  // derived pins lag a register write by one cycle and an input pin by three
  task automatic settle;
    repeat (6) @(posedge mclk);
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    print_verdict;
  end
  initial begin
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    settle;
    chk(first_cycle_waits, 32'h1);
    chk(bank_miss_waits, 32'h3);
    chk(shutdown_cycles, 32'h10);
    chk(bios_rom_select_n, 32'h0);
    rd_chk(`MTCFG_IDX_ROMCFG, 32'h1);
    sys_mgmt_interrupt <= 1'b1;
    settle;
    rd_chk(`MTCFG_IDX_VERSION, 32'hCD);
    sys_mgmt_interrupt <= 1'b0;
    wr(`MTCFG_IDX_VERSION, 8'h13);
    settle;
    rd_chk(`MTCFG_IDX_VERSION, 32'h4D);
    chk(enhanced_page_enable, 32'h1);
    ext_cfg_bit7 <= 1'b1;
    settle;
    chk(enhanced_page_enable, 32'h0);
    ext_cfg_bit7 <= 1'b0;
    mem_bank_cfg <= 3'h3;
    settle;
    chk(enhanced_page_enable, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(`MTCFG_IDX_VERSION, 8'(i));
      settle;
      chk(refresh_rate, rate[i]);
      chk(enhanced_page_enable, 32'h0);
    end
    power_manager <= 2'h1;
    settle;
    chk(refresh_from_regs, 32'h0);
    power_manager <= 2'h0;
    sys_mgmt_interrupt <= 1'b1;
    mem_addr <= 24'h064000;
    for (int i = 0; i < 16; i++) begin
      w = {i[3], i[2], i[1], i[0], i[0], i[1], 1'b0, i[2]};
      wr(`MTCFG_IDX_WAIT, w);
      wr(`MTCFG_IDX_ROMCFG, {2'h0, i[3], 5'h01});
      wr(`MTCFG_IDX_EXT, {7'h0, i[2] ^ i[0]});
      settle;
      chk(first_cycle_waits, i[3] ? (w[5] ? 32'h3 : 32'h2) : (w[4] ? 32'h2 : 32'h1));
      chk(bank_miss_waits, (i[2] ^ i[0]) ? (w[6] ? 32'h5 : 32'h4) : 32'h3);
      chk(internal_io_waits, w[3] ? 32'h2 : 32'h4);
      chk(wide_io_waits, w[2] ? 32'h3 : 32'h4);
      chk(shutdown_cycles, w[0] ? 32'h20 : 32'h10);
      chk(sys_mgmt_window_hit, w[7]);
      rd_chk(`MTCFG_IDX_STATUS, i[2] ^ i[0]);
    end
    wr(`MTCFG_IDX_WAIT, 8'h60);
    wr(`MTCFG_IDX_ROMCFG, 8'h21);
    wr(`MTCFG_IDX_EXT, 8'h01);
    settle;
    chk(first_cycle_waits, 32'h3);
    chk(bank_miss_waits, 32'h5);
    chk(refresh_from_regs, 32'h1);
    sys_mgmt_interrupt <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      wr(`MTCFG_IDX_ROMCFG, s == 3 ? 8'h00 : (8'h08 >> s) | 8'h01);
      rd_chk(`MTCFG_IDX_ROMCFG, s == 3 ? 32'h1 : 32'h8 >> s);
      for (int k = 0; k < 4; k++) begin
        mem_addr <= seg[k];
        settle;
        chk(bios_rom_select_n, k != s);
      end
    end
    rdr(`MTCFG_IDX_ROMCFG);
    wr(`MTCFG_IDX_ROMCFG, (rd[7:0] ^ 8'h01) | 8'h20);
    settle;
    chk(bios_rom_select_n, 32'h0);
    rd_chk(`MTCFG_IDX_ROMCFG, 32'h21);
    mem_addr <= 24'h0C8000;
    wr(`MTCFG_IDX_ROMCFG, 8'h91);
    settle;
    chk(shadow_hit, 32'h1);
    chk(shadow_write_ok, 32'h1);
    wr(`MTCFG_IDX_ROMCFG, 8'h51);
    settle;
    chk(shadow_write_ok, 32'h0);
    chk(window_active, 32'h1);
    window_page_en <= 1'b0;
    settle;
    chk(window_active, 32'h0);
    window_page_en <= 1'b1;
    wr(`MTCFG_IDX_ROMCFG, 8'h01);
    settle;
    chk(window_active, 32'h0);
    rdr(8'h10);
    chk(rs, 32'h2);
    chk(rd, 32'h0);
    wr(8'h10, 8'h55);
    chk(rs, 32'h2);
    print_verdict;
  end
endmodule
